// ### verilog/fopr_fifo_dev.sv
// fifo end: storage, offset registers, flags and retransmit
`timescale 1ns/1ps
module fopr_fifo_dev #(
    parameter int DEPTH = fopr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // mode straps, taken during master reset
    input  wire logic [1:0] in_width,
    input  wire logic [1:0] out_width,
    input  wire logic       fall_through_mode,
    input  wire logic       zero_latency,
    // pins
    fopr_if.dev             pins
);
    localparam int AW = $clog2(DEPTH);
    localparam int DW = fopr_pkg::DATA_W;
    localparam int OW = fopr_pkg::OFS_W;

    logic [DW-1:0]  mem_q [DEPTH];
    logic [AW:0]    wptr_q;
    logic [AW:0]    rptr_q;
    logic [DW-1:0]  dout_q;
    logic           ov_q;
    logic [OW-1:0]  ofs_empty_q;
    logic [OW-1:0]  ofs_full_q;
    logic           ae_ok_q;
    logic           af_ok_q;
    logic           ae_s1_q;
    logic           ae_q;
    logic           af_s1_q;
    logic           af_q;
    logic [1:0]     iw_q;
    logic [1:0]     ow_q;
    logic           fall_through_mode_q;
    logic           zl_q;
    logic [1:0]     rt_cnt_q;
    fopr_pkg::fopr_rt_state_t rt_state_q;

    logic           wsel;
    logic           wlast;
    logic [4:0]     wshift;
    logic [31:0]    wmask;
    logic           rsel;
    logic [4:0]     rshift;
    logic [31:0]    rmask;

    // decode of pin strobes
    wire mr       = rst || !pins.master_reset_n;
    wire pr       = !pins.partial_reset_n;
    wire wr_edge  = pins.tick_wr;
    wire rd_edge  = pins.tick_rd;
    wire ld_n     = pins.offset_load_n;
    wire ofs_wr   = wr_edge && !ld_n && !pins.write_en_n;
    wire ofs_rd   = rd_edge && !ld_n && !pins.read_en_n;
    wire [AW:0] count = wptr_q - rptr_q;
    wire empty    = (count == '0);
    wire full     = (count == (AW+1)'(DEPTH));
    wire rt_idle  = (rt_state_q == fopr_pkg::RT_IDLE);
    wire rt_take  = rd_edge && !pins.retransmit_n && rt_idle;
    wire rt_done  = (rt_state_q == fopr_pkg::RT_SETUP) && rd_edge && (rt_cnt_q == 2'h1);
    wire rd_ok    = rd_edge && ld_n && !pins.read_en_n && rt_idle && !rt_take;
    wire fifo_wr  = wr_edge && ld_n && !pins.write_en_n && !full;
    // standard mode needs read enable for every word
    wire std_rd   = !fall_through_mode_q && rd_ok && !empty;
    wire fall_through_mode_ld  = fall_through_mode_q && rd_edge && rt_idle && !rt_take && !empty && !ofs_rd &&
                    (!ov_q || rd_ok);
    wire fall_through_mode_drn = fall_through_mode_q && rd_ok && ov_q && empty;
    wire mem_rd   = std_rd || fall_through_mode_ld;
    wire first_ld = (rt_take && zl_q) || (rt_done && fall_through_mode_q);

    // offset merge and readback
    wire [OW-1:0] wcur   = wsel ? ofs_full_q : ofs_empty_q;
    wire [OW-1:0] wmerge = (wcur & ~(wmask << wshift)) |
                           ((pins.input_data_bus[OW-1:0] & wmask) << wshift);
    wire [OW-1:0] rcur   = rsel ? ofs_full_q : ofs_empty_q;
    wire [OW-1:0] rpart  = (rcur >> rshift) & rmask;
    wire [OW-1:0] cnt_w  = OW'(count);
    wire          ae_hit = (cnt_w <= ofs_empty_q);
    wire          af_hit = ({1'b0, cnt_w} + {1'b0, ofs_full_q}) >= (OW+1)'(DEPTH);

    fopr_seq_ptr u_wseq (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clear   (!pins.master_reset_n),
        .step    (ofs_wr),
        .width   (iw_q),
        .sel     (wsel),
        .last    (wlast),
        .shift   (wshift),
        .mask    (wmask)
    );

    fopr_seq_ptr u_rseq (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clear   (!pins.master_reset_n),
        .step    (ofs_rd),
        .width   (ow_q),
        .sel     (rsel),
        .last    (),
        .shift   (rshift),
        .mask    (rmask)
    );

    // straps follow the pins while master reset is held
    always_ff @(posedge sys_clk) begin
        if (mr) begin
            iw_q   <= in_width;
            ow_q   <= out_width;
            fall_through_mode_q <= fall_through_mode;
            zl_q   <= zero_latency;
        end
    end

    // storage is untouched by offset accesses
    always_ff @(posedge sys_clk) begin
        if (fifo_wr) begin
            mem_q[wptr_q[AW-1:0]] <= pins.input_data_bus;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            wptr_q <= '0;
        end else if (fifo_wr) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            rptr_q <= '0;
        end else if (first_ld) begin
            rptr_q <= (AW+1)'(1);
        end else if (rt_take) begin
            rptr_q <= '0;
        end else if (mem_rd) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

    // output register; readback has priority over memory
    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            dout_q <= '0;
        end else if (ofs_rd) begin
            dout_q <= {{(DW-OW){1'b0}}, rpart};
        end else if (first_ld) begin
            dout_q <= mem_q[0];
        end else if (mem_rd) begin
            dout_q <= mem_q[rptr_q[AW-1:0]];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            ov_q <= 1'b0;
        end else if (first_ld || fall_through_mode_ld) begin
            ov_q <= fall_through_mode_q;
        end else if ((rt_take && !zl_q) || fall_through_mode_drn) begin
            ov_q <= 1'b0;
        end
    end

    // retransmit setup sequencer
    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            rt_state_q <= fopr_pkg::RT_IDLE;
            rt_cnt_q   <= 2'h0;
        end else begin
            case (rt_state_q)
                fopr_pkg::RT_IDLE: begin
                    if (rt_take && !zl_q) begin
                        rt_state_q <= fopr_pkg::RT_SETUP;
                        rt_cnt_q   <= fopr_pkg::RT_SETUP_EDGES;
                    end
                end
                fopr_pkg::RT_SETUP: begin
                    if (rt_done) begin
                        rt_state_q <= fopr_pkg::RT_IDLE;
                    end else if (rd_edge) begin
                        rt_cnt_q <= rt_cnt_q - 2'h1;
                    end
                end
                default: begin
                    rt_state_q <= fopr_pkg::RT_IDLE;
                end
            endcase
        end
    end

    // offset registers survive partial reset
    always_ff @(posedge sys_clk) begin
        if (mr) begin
            ofs_empty_q <= fopr_pkg::DEF_EMPTY_OFS;
            ofs_full_q  <= fopr_pkg::DEF_FULL_OFS;
        end else if (ofs_wr && !wsel) begin
            ofs_empty_q <= wmerge;
        end else if (ofs_wr) begin
            ofs_full_q <= wmerge;
        end
    end

    // a flag is invalid between the first and last part of its register
    always_ff @(posedge sys_clk) begin
        if (mr) begin
            ae_ok_q <= 1'b1;
            af_ok_q <= 1'b1;
        end else if (ofs_wr) begin
            if (!wsel) begin
                ae_ok_q <= wlast;
            end else begin
                af_ok_q <= wlast;
            end
        end
    end

    // two-stage flag pipes give the two-edge delay after programming and retransmit
    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            ae_s1_q <= 1'b0;
            ae_q    <= 1'b0;
        end else if (rd_edge) begin
            ae_s1_q <= ae_ok_q ? !ae_hit : 1'b1;
            ae_q    <= ae_s1_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mr || pr) begin
            af_s1_q <= 1'b1;
            af_q    <= 1'b1;
        end else if (wr_edge) begin
            af_s1_q <= af_ok_q ? !af_hit : 1'b1;
            af_q    <= af_s1_q;
        end
    end

    assign pins.output_data_bus     = dout_q;
    assign pins.empty_flag_n        = !(empty || !rt_idle);
    assign pins.full_flag_n         = !full;
    assign pins.half_full_flag_n    = !(count > (AW+1)'(DEPTH / 2));
    assign pins.almost_empty_flag_n = ae_q;
    assign pins.almost_full_flag_n  = af_q;
    assign pins.output_ready_n      = !ov_q;
endmodule

// ### verilog/fopr_pkg.sv
// shared constants and types for the offset-programmable fifo and its controller
package fopr_pkg;
    localparam int          FIFO_DEPTH     = 1024;
    localparam int          DATA_W         = 36;
    localparam int          OFS_W          = 32;
    // bus width straps
    localparam logic [1:0]  BW_36          = 2'h0;
    localparam logic [1:0]  BW_18          = 2'h1;
    localparam logic [1:0]  BW_9           = 2'h2;
    // parts per offset register
    localparam logic [2:0]  PARTS_36       = 3'h1;
    localparam logic [2:0]  PARTS_18       = 3'h2;
    localparam logic [2:0]  PARTS_9        = 3'h3;
    localparam logic [31:0] MASK_36        = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_18        = 32'h0000_FFFF;
    localparam logic [31:0] MASK_9         = 32'h0000_00FF;
    localparam logic [4:0]  SHIFT_18       = 5'h10;
    localparam logic [4:0]  SHIFT_9        = 5'h08;
    // offsets after master reset
    localparam logic [31:0] DEF_EMPTY_OFS  = 32'h0000_007F;
    localparam logic [31:0] DEF_FULL_OFS   = 32'h0000_007F;
    localparam logic [1:0]  RT_SETUP_EDGES = 2'h2;
    localparam int          TICK_DIV       = 4;
    localparam int          RT_MIN_WORDS   = 2;
    localparam int          RT_MARGIN      = 2;
    // controller register map
    localparam logic [7:0]  REG_CMD        = 8'h00;
    localparam logic [7:0]  REG_WDATA_LO   = 8'h04;
    localparam logic [7:0]  REG_WDATA_HI   = 8'h08;
    localparam logic [7:0]  REG_RDATA_LO   = 8'h0C;
    localparam logic [7:0]  REG_RDATA_HI   = 8'h10;
    localparam logic [7:0]  REG_STATUS     = 8'h14;
    localparam logic [7:0]  REG_MODE       = 8'h18;
    localparam int          ST_REFUSED     = 1;

    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_FIFO_WR = 3'h1,
        OP_FIFO_RD = 3'h2,
        OP_OFS_WR  = 3'h3,
        OP_OFS_RD  = 3'h4,
        OP_RETX    = 3'h5,
        OP_MRESET  = 3'h6,
        OP_PRESET  = 3'h7
    } fopr_op_t;

    typedef enum logic [1:0] {
        RT_IDLE  = 2'b01,
        RT_SETUP = 2'b10
    } fopr_rt_state_t;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_ARM  = 3'b010,
        CS_CAPT = 3'b100
    } fopr_ctl_state_t;
endpackage

// ### verilog/fopr_if.sv
// pin-level link between the fifo and its controller
`timescale 1ns/1ps
interface fopr_if;
    logic        tick_wr;
    logic        tick_rd;
    logic        master_reset_n;
    logic        partial_reset_n;
    logic        offset_load_n;
    logic        write_en_n;
    logic        read_en_n;
    logic        retransmit_n;
    logic [35:0] input_data_bus;
    logic [35:0] output_data_bus;
    logic        empty_flag_n;
    logic        full_flag_n;
    logic        half_full_flag_n;
    logic        almost_empty_flag_n;
    logic        almost_full_flag_n;
    logic        output_ready_n;

    modport dev (
        input  tick_wr, tick_rd, master_reset_n, partial_reset_n, offset_load_n,
        input  write_en_n, read_en_n, retransmit_n, input_data_bus,
        output output_data_bus, empty_flag_n, full_flag_n, half_full_flag_n,
        output almost_empty_flag_n, almost_full_flag_n, output_ready_n
    );
    modport ctl (
        output tick_wr, tick_rd, master_reset_n, partial_reset_n, offset_load_n,
        output write_en_n, read_en_n, retransmit_n, input_data_bus,
        input  output_data_bus, empty_flag_n, full_flag_n, half_full_flag_n,
        input  almost_empty_flag_n, almost_full_flag_n, output_ready_n
    );
endinterface

// ### verilog/fopr_seq_ptr.sv
// offset register part sequencer, one per access direction
`timescale 1ns/1ps
module fopr_seq_ptr (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // control
    input  wire logic        clear,
    input  wire logic        step,
    input  wire logic [1:0]  width,
    // current part
    output logic             sel,
    output logic             last,
    output logic [4:0]       shift,
    output logic [31:0]      mask
);
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic [2:0] part;
    wire  [2:0] ppr = (width == fopr_pkg::BW_18) ? fopr_pkg::PARTS_18 :
                      (width == fopr_pkg::BW_9)  ? fopr_pkg::PARTS_9  : fopr_pkg::PARTS_36;
    wire  [2:0] total = 3'(ppr << 1);

    assign sel   = (idx_q >= ppr);
    assign part  = sel ? 3'(idx_q - ppr) : idx_q;
    assign last  = (part == 3'(ppr - 3'h1));
    assign shift = (width == fopr_pkg::BW_18) ? (part[0] ? fopr_pkg::SHIFT_18 : 5'h00) :
                   (width == fopr_pkg::BW_9)  ? 5'({part, 3'h0}) : 5'h00;
    assign mask  = (width == fopr_pkg::BW_18) ? fopr_pkg::MASK_18 :
                   (width == fopr_pkg::BW_9)  ? fopr_pkg::MASK_9  : fopr_pkg::MASK_36;
    // wrap after the last part of the full register
    assign idx_d = (idx_q == 3'(total - 3'h1)) ? 3'h0 : 3'(idx_q + 3'h1);

    always_ff @(posedge sys_clk) begin
        if (rst || clear) begin
            idx_q <= 3'h0;
        end else if (step) begin
            idx_q <= idx_d;
        end
    end
endmodule

// ### verilog/fopr_fifo_ctl.sv
// controller end: apb registers, clock-edge divider and pin sequencer
`timescale 1ns/1ps
module fopr_fifo_ctl #(
    parameter int DEPTH    = fopr_pkg::FIFO_DEPTH,
    parameter int TICK_DIV = fopr_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    fopr_if.ctl              pins
);
    logic [7:0]   div_q;
    logic         tick_q;
    logic [35:0]  wdata_q;
    logic [35:0]  rdata_q;
    logic [31:0]  prdata_q;
    logic         refused_q;
    logic         fall_through_mode_q;
    logic [11:0]  wr_cnt_q;
    logic [11:0]  rd_cnt_q;
    fopr_pkg::fopr_op_t        op_q;
    fopr_pkg::fopr_ctl_state_t st_q;

    wire        acc     = psel && penable;
    wire        wr_acc  = acc && pwrite;
    wire        mapped  = (paddr <= fopr_pkg::REG_MODE) && (paddr[1:0] == 2'h0);
    wire        idle    = (st_q == fopr_pkg::CS_IDLE);
    wire        cmd_wr  = wr_acc && (paddr == fopr_pkg::REG_CMD);
    wire [2:0]  cmd_op  = pwdata[2:0];
    wire [11:0] limit   = 12'(DEPTH - fopr_pkg::RT_MARGIN + (fall_through_mode_q ? 1 : 0));
    wire        rt_fit  = (wr_cnt_q >= 12'(fopr_pkg::RT_MIN_WORDS)) && (rd_cnt_q >= 12'(fopr_pkg::RT_MIN_WORDS)) &&
                          (wr_cnt_q <= limit) && (rd_cnt_q <= limit);
    wire        is_rt   = (cmd_op == fopr_pkg::OP_RETX);
    wire        accept  = cmd_wr && idle && (cmd_op != fopr_pkg::OP_NONE) && (!is_rt || rt_fit);
    wire        refuse  = cmd_wr && !accept;
    wire        clr_ref = wr_acc && (paddr == fopr_pkg::REG_STATUS) && pwdata[fopr_pkg::ST_REFUSED];
    wire        arm     = (st_q == fopr_pkg::CS_ARM);
    wire        fire    = arm && tick_q;
    wire        is_op_w = (op_q == fopr_pkg::OP_FIFO_WR) || (op_q == fopr_pkg::OP_OFS_WR);
    wire        is_op_r = (op_q == fopr_pkg::OP_FIFO_RD) || (op_q == fopr_pkg::OP_OFS_RD);
    wire        is_ofs  = (op_q == fopr_pkg::OP_OFS_WR) || (op_q == fopr_pkg::OP_OFS_RD);
    wire        is_rst  = (op_q == fopr_pkg::OP_MRESET) || (op_q == fopr_pkg::OP_PRESET);
    wire [7:0]  status  = {!pins.output_ready_n, !pins.almost_full_flag_n, !pins.almost_empty_flag_n,
                           !pins.half_full_flag_n, !pins.full_flag_n, !pins.empty_flag_n, refused_q, !idle};
    wire [31:0] rd_mux  = (paddr == fopr_pkg::REG_WDATA_LO) ? wdata_q[31:0] :
                          (paddr == fopr_pkg::REG_WDATA_HI) ? {28'h000_0000, wdata_q[35:32]} :
                          (paddr == fopr_pkg::REG_RDATA_LO) ? rdata_q[31:0] :
                          (paddr == fopr_pkg::REG_RDATA_HI) ? {28'h000_0000, rdata_q[35:32]} :
                          (paddr == fopr_pkg::REG_STATUS)   ? {24'h00_0000, status} :
                          (paddr == fopr_pkg::REG_MODE)     ? {31'h0000_0000, fall_through_mode_q} : 32'h0000_0000;

    // free-running edge divider, shared by both sides
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 8'(TICK_DIV - 1));
            div_q  <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : 8'(div_q + 8'h01);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wdata_q  <= '0;
            fall_through_mode_q   <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (psel && !penable) begin
                prdata_q <= rd_mux;
            end
            if (wr_acc && paddr == fopr_pkg::REG_WDATA_LO) begin
                wdata_q[31:0] <= pwdata;
            end
            if (wr_acc && paddr == fopr_pkg::REG_WDATA_HI) begin
                wdata_q[35:32] <= pwdata[3:0];
            end
            if (wr_acc && paddr == fopr_pkg::REG_MODE) begin
                fall_through_mode_q <= pwdata[0];
            end
        end
    end

    // refusal wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (refuse) begin
            refused_q <= 1'b1;
        end else if (clr_ref) begin
            refused_q <= 1'b0;
        end
    end

    // one operation at a time keeps offset reads and writes apart
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= fopr_pkg::CS_IDLE;
            op_q <= fopr_pkg::OP_NONE;
        end else begin
            case (st_q)
                fopr_pkg::CS_IDLE: begin
                    if (accept) begin
                        op_q <= fopr_pkg::fopr_op_t'(cmd_op);
                        st_q <= fopr_pkg::CS_ARM;
                    end
                end
                fopr_pkg::CS_ARM: begin
                    if (tick_q) begin
                        st_q <= fopr_pkg::CS_CAPT;
                    end
                end
                fopr_pkg::CS_CAPT: begin
                    st_q <= fopr_pkg::CS_IDLE;
                end
                default: begin
                    st_q <= fopr_pkg::CS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q  <= '0;
            wr_cnt_q <= 12'h000;
            rd_cnt_q <= 12'h000;
        end else begin
            if (st_q == fopr_pkg::CS_CAPT && is_op_r) begin
                rdata_q <= pins.output_data_bus;
            end
            if (fire && is_rst) begin
                wr_cnt_q <= 12'h000;
                rd_cnt_q <= 12'h000;
            end
            if (fire && op_q == fopr_pkg::OP_FIFO_WR && wr_cnt_q != 12'hFFF) begin
                wr_cnt_q <= 12'(wr_cnt_q + 12'h001);
            end
            if (fire && op_q == fopr_pkg::OP_FIFO_RD && rd_cnt_q != 12'hFFF) begin
                rd_cnt_q <= 12'(rd_cnt_q + 12'h001);
            end
        end
    end

    // enables rest high, so retransmit always sees them high
    assign pins.tick_wr         = tick_q;
    assign pins.tick_rd         = tick_q;
    assign pins.offset_load_n   = !(arm && is_ofs);
    assign pins.write_en_n      = !(arm && is_op_w);
    assign pins.read_en_n       = !(arm && is_op_r);
    assign pins.retransmit_n    = !(arm && op_q == fopr_pkg::OP_RETX);
    assign pins.master_reset_n  = !(arm && op_q == fopr_pkg::OP_MRESET);
    assign pins.partial_reset_n = !(arm && op_q == fopr_pkg::OP_PRESET);
    assign pins.input_data_bus  = wdata_q;
    assign prdata               = prdata_q;
    assign pready               = penable;
    assign pslverr              = acc && !mapped;
endmodule

// ### verif/fopr_assertions.sv
// pin-link checker for the fifo and its controller
`timescale 1ns/1ps
module fopr_assertions (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // controller side
    input wire logic        tick_wr,
    input wire logic        tick_rd,
    input wire logic        master_reset_n,
    input wire logic        partial_reset_n,
    input wire logic        offset_load_n,
    input wire logic        write_en_n,
    input wire logic        read_en_n,
    input wire logic        retransmit_n,
    input wire logic        zero_latency,
    // fifo side
    input wire logic [35:0] output_data_bus,
    input wire logic        empty_flag_n,
    input wire logic        half_full_flag_n,
    input wire logic        almost_empty_flag_n,
    input wire logic        almost_full_flag_n
);
    // resets also move the almost flags, so they count as a flag event
    wire w_ev = tick_wr || !master_reset_n || !partial_reset_n;
    wire r_ev = tick_rd || !master_reset_n || !partial_reset_n;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence rt_start;
        tick_rd && !retransmit_n;
    endsequence
    // zero latency skips the setup phase
    sequence rt_setup;
        tick_rd && !retransmit_n && !zero_latency;
    endsequence
    sequence ofs_wr;
        tick_wr && !offset_load_n && !write_en_n;
    endsequence
    sequence ofs_rd;
        tick_rd && !offset_load_n && !read_en_n;
    endsequence
    a_no_dual_ofs: assert property (!(!offset_load_n && !write_en_n && !read_en_n))
        else $error("offset read and write together");
    a_rt_enables_high: assert property (rt_start |-> write_en_n && read_en_n)
        else $error("enable low at retransmit");
    a_rt_empty_low: assert property (rt_setup |=> !empty_flag_n [*4])
        else $error("empty flag not low in setup");
    a_rt_setup_end: assert property (rt_start |-> ##[5:16] empty_flag_n)
        else $error("retransmit setup never ends");
    a_ofs_wr_routed: assert property (ofs_wr |=> $stable(half_full_flag_n) && $stable(empty_flag_n))
        else $error("offset write touched fifo");
    a_ofs_rd_zext: assert property (ofs_rd |=> output_data_bus[35:32] == 4'h0)
        else $error("readback not on output bus");
    a_mreset_flags: assert property (!master_reset_n |=> !empty_flag_n && !almost_empty_flag_n && almost_full_flag_n)
        else $error("flags wrong after master reset");
    a_af_write_tick: assert property ($changed(almost_full_flag_n) |-> $past(w_ev))
        else $error("almost full moved off write tick");
    a_ae_read_tick: assert property ($changed(almost_empty_flag_n) |-> $past(r_ev))
        else $error("almost empty moved off read tick");
endmodule

// ### verif/fifo_offset_prog_retransmit_tb.sv
// bench: offset load and readback over all widths, then retransmit
`timescale 1ns/1ps
module fifo_offset_prog_retransmit_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, ofs [6];
    logic [1:0]  bw = 2'h0;
    logic        fw = 1'b0, zl = 1'b0;
    int          err_total = 0, check_count = 0, cyc = 0, n;
    fopr_if pins ();
    fopr_fifo_dev u_fopr_fifo_dev (.sys_clk(sys_clk), .rst(rst), .in_width(bw), .out_width(bw),
        .fall_through_mode(fw), .zero_latency(zl), .pins(pins.dev));
    fopr_fifo_ctl u_fopr_fifo_ctl (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins.ctl));
    fopr_assertions u_fopr_assertions (.sys_clk(sys_clk), .rst(rst), .tick_wr(pins.tick_wr),
        .tick_rd(pins.tick_rd), .master_reset_n(pins.master_reset_n),
        .partial_reset_n(pins.partial_reset_n), .offset_load_n(pins.offset_load_n),
        .write_en_n(pins.write_en_n), .read_en_n(pins.read_en_n), .retransmit_n(pins.retransmit_n),
        .output_data_bus(pins.output_data_bus), .empty_flag_n(pins.empty_flag_n), .zero_latency(zl),
        .half_full_flag_n(pins.half_full_flag_n), .almost_empty_flag_n(pins.almost_empty_flag_n),
        .almost_full_flag_n(pins.almost_full_flag_n));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    function automatic logic [31:0] pmask(input logic [1:0] w);
        return w == fopr_pkg::BW_36 ? fopr_pkg::MASK_36 : w == fopr_pkg::BW_18 ? fopr_pkg::MASK_18 : fopr_pkg::MASK_9;
    endfunction
    function automatic int nparts(input logic [1:0] w);
        return 2 * (w == fopr_pkg::BW_36 ? 1 : w == fopr_pkg::BW_18 ? 2 : 3);
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // every op waits for busy to drop, so pin sequences never overlap
    task op(input fopr_pkg::fopr_op_t c, input logic [31:0] d);
        apb(1'b1, fopr_pkg::REG_WDATA_LO, d);
        apb(1'b1, fopr_pkg::REG_CMD, {29'h0000_0000, c});
        do apb(1'b0, fopr_pkg::REG_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
    endtask
    task rdback(input fopr_pkg::fopr_op_t c, input string nm, input logic [31:0] exp);
        op(c, 32'h0000_0000);
        apb(1'b0, fopr_pkg::REG_RDATA_LO, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'ha783));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        for (int w = 0; w < 3; w++) begin
            bw <= w[1:0];
            op(fopr_pkg::OP_MRESET, 32'h0000_0000);
            apb(1'b0, fopr_pkg::REG_STATUS, 32'h0000_0000);
            chk("status after reset", rd & 32'h0000_00FF, 32'h0000_0024);
            n = nparts(bw);
            for (int i = 0; i < n; i++) begin
                ofs[i] = $urandom();
                op(fopr_pkg::OP_OFS_WR, ofs[i]);
                if (i == 0) op(fopr_pkg::OP_FIFO_WR, $urandom());
                if (i == 1) op(fopr_pkg::OP_PRESET, 32'h0000_0000);
            end
            // one read past the end checks the wrap back to the first part
            for (int i = 0; i <= n; i++) begin
                rdback(fopr_pkg::OP_OFS_RD, "offset readback", ofs[i % n] & pmask(bw));
                if (i == 1) op(fopr_pkg::OP_FIFO_RD, 32'h0000_0000);
            end
        end
        for (int m = 0; m < 3; m++) begin
            fw <= m[0];
            zl <= m[1];
            apb(1'b1, fopr_pkg::REG_MODE, m);
            op(fopr_pkg::OP_MRESET, 32'h0000_0000);
            op(fopr_pkg::OP_RETX, 32'h0000_0000);
            apb(1'b0, fopr_pkg::REG_STATUS, 32'h0000_0000);
            chk("early retransmit refused", rd & 32'h0000_0002, 32'h0000_0002);
            apb(1'b1, fopr_pkg::REG_STATUS, 32'h0000_0002);
            for (int i = 0; i < 3; i++) begin
                ofs[i] = $urandom();
                op(fopr_pkg::OP_FIFO_WR, ofs[i]);
            end
            // a preloaded output means a read shows the word behind it
            for (int i = 0; i < 3; i++)
                rdback(fopr_pkg::OP_FIFO_RD, "fifo read", ofs[fw && i < 2 ? i + 1 : i]);
            op(fopr_pkg::OP_RETX, 32'h0000_0000);
            apb(1'b0, fopr_pkg::REG_STATUS, 32'h0000_0000);
            chk("retransmit taken", rd & 32'h0000_0002, 32'h0000_0000);
            do apb(1'b0, fopr_pkg::REG_STATUS, 32'h0000_0000); while (rd[2] !== 1'b0);
            chk("output ready", {31'h0000_0000, rd[7]}, {31'h0000_0000, fw});
            for (int i = 0; i < 3; i++)
                rdback(fopr_pkg::OP_FIFO_RD, "retransmit read", ofs[(fw || zl) && i < 2 ? i + 1 : i]);
        end
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped error", {31'h0000_0000, er}, 32'h0000_0001);
        test_done();
    end
endmodule
